// ---- pmw_ctrl.sv ----
// pmw_ctrl: global power mode controller with wakeup logic and timewheel.
// assumes wake sources and the 1 kHz tick arrive asynchronously on pins.
//
// What this block does
// R1: four global modes: active, alternate active, sleep, hibernate.
// R2: in active, one template bit per subsystem enables that subsystem.
// R3: a subsystem disabled by its template bit has its clocks gated.
// R4: cpu may disable itself; it is re-enabled on the next wakeup.
// R5: any wakeup returns mode to active and enables the cpu.
// R6: after boot the mode is active.
// R7: alternate active applies its own template.
// R8: sleep disables all subsystems regardless of templates.
// R9: sleep resumes to active within 12 us.
// R10: only a pin interrupt wakes from hibernate.
// R11: hibernate resumes to active in under 100 us.
// R12: hibernate keeps state, pin outputs, pin irq settings; clocks stop.
// R13: supply below retention level in hibernate gives a low-voltage reset; the code gives it only before the wake, not during the resume count.
// R14: wake sources individually enabled; interrupts or resets; all go active.
// R15: interrupt wakes: peripheral, supervisor, timewheel, pin.
// R16: reset wakes: external pin, watchdog, precise low-voltage reset.
// R17: firmware disables the pll before a low-power request.
// R18: 13-bit timewheel at 1 kHz runs in every mode but hibernate.
// R19: asynchronous wake requests are synchronised before state changes.
`timescale 1ns/100ps
module pmw_ctrl (
    // clock and reset
    input  wire logic                                clock_i,
    input  wire logic                                reset_i,
    // mode request from firmware
    input  wire logic                                mode_req_i,
    input  wire pmw_pkg::pmw_mode_t                  mode_sel_i,
    input  wire logic [pmw_pkg::NUM_SUBSYS-1:0]      act_template_i,
    input  wire logic [pmw_pkg::NUM_SUBSYS-1:0]      alt_template_i,
    // wake sources (asynchronous)
    input  wire logic [pmw_pkg::NUM_IRQ-1:0]         irq_i,
    input  wire logic [pmw_pkg::NUM_IRQ-1:0]         irq_wake_en_i,
    input  wire logic                                external_reset_pin_n_i,
    input  wire logic                                watchdog_reset_i,
    input  wire logic                                precise_low_voltage_reset_i,
    input  wire logic [2:0]                          rst_wake_en_i,
    input  wire logic                                supply_low_i,
    input  wire logic                                tick_1khz_i,
    input  wire logic                                tw_clear_i,
    // status and control outputs
    output pmw_pkg::pmw_mode_t                       mode_o,
    output logic [pmw_pkg::NUM_SUBSYS-1:0]           subsys_en_o,
    output logic [pmw_pkg::NUM_SUBSYS-1:0]           clk_gate_en_o,
    output logic                                     clocks_run_o,
    output logic                                     retain_o,
    output logic                                     wake_pulse_o,
    output logic                                     hibernate_low_voltage_reset_o,
    output logic [pmw_pkg::TW_WIDTH-1:0]             central_timewheel_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [pmw_pkg::NUM_IRQ-1:0]   irq_s1;
        logic [pmw_pkg::NUM_IRQ-1:0]   irq_s2;
        logic [2:0]                    rst_s1;
        logic [2:0]                    rst_s2;
        logic                          low_s1;
        logic                          low_s2;
        logic                          tick_s1;
        logic                          tick_s2;
        logic                          tick_s3;
        pmw_pkg::pmw_mode_t            mode;
        pmw_pkg::pmw_state_t           state;
        logic                          cpu_off;
        logic [pmw_pkg::RESUME_W-1:0]  resume_cnt;
        logic [pmw_pkg::TW_WIDTH-1:0]  tw;
        logic                          wake;
        logic                          hibernate_low_voltage_reset;
        logic [pmw_pkg::NUM_SUBSYS-1:0] en;
    } pmw_regs_t;

    pmw_regs_t s_q;
    pmw_regs_t s_d;

    logic [2:0] rst_raw;
    assign rst_raw = {precise_low_voltage_reset_i, watchdog_reset_i, ~external_reset_pin_n_i};

    // wake qualification per mode
    function automatic logic wake_allowed(input pmw_pkg::pmw_mode_t m,
                                          input logic [pmw_pkg::NUM_IRQ-1:0] irq,
                                          input logic [2:0] rst);
        if (m == pmw_pkg::PMW_HIBERNATE) begin
            wake_allowed = irq[pmw_pkg::SRC_PIN]; // [R10]
        end else begin
            wake_allowed = (|irq) | (|rst); // [R14] [R15] [R16]
        end
    endfunction

    logic [pmw_pkg::NUM_IRQ-1:0] irq_q;
    logic [2:0]                  rst_q;
    logic                        wake_ev;
    assign irq_q   = s_q.irq_s2 & irq_wake_en_i;
    assign rst_q   = s_q.rst_s2 & rst_wake_en_i;
    assign wake_ev = wake_allowed(s_q.mode, irq_q, rst_q);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d         = s_q;
        // only the second stages, and tick_s3 for edge detection, feed logic [R19]
        s_d.irq_s1  = irq_i;
        s_d.irq_s2  = s_q.irq_s1;
        s_d.rst_s1  = rst_raw;
        s_d.rst_s2  = s_q.rst_s1;
        s_d.low_s1  = supply_low_i;
        s_d.low_s2  = s_q.low_s1;
        s_d.tick_s1 = tick_1khz_i;
        s_d.tick_s2 = s_q.tick_s1;
        s_d.tick_s3 = s_q.tick_s2;
        s_d.wake    = 1'b0;
        s_d.hibernate_low_voltage_reset    = 1'b0;

        // timewheel frozen only in hibernate [R18]
        if (tw_clear_i) begin
            s_d.tw = pmw_pkg::TW_RESET;
        end else if (s_q.mode != pmw_pkg::PMW_HIBERNATE && s_q.tick_s2 && !s_q.tick_s3) begin
            s_d.tw = s_q.tw + 1'b1;
        end

        case (s_q.state)
            pmw_pkg::PMW_RUN: begin
                // a source held high keeps re-raising the wake; firmware must clear it
                if (wake_ev) begin
                    s_d.mode    = pmw_pkg::PMW_ACTIVE; // [R5]
                    s_d.cpu_off = 1'b0; // [R4]
                    s_d.wake    = 1'b1;
                end else if (mode_req_i) begin
                    s_d.mode = mode_sel_i; // [R1]
                    if (mode_sel_i == pmw_pkg::PMW_SLEEP || mode_sel_i == pmw_pkg::PMW_HIBERNATE) begin
                        s_d.state = pmw_pkg::PMW_LOWPWR;
                    end
                end
                // cpu clearing its own bit latches it off until a wakeup [R4]
                if (!wake_ev && s_q.mode == pmw_pkg::PMW_ACTIVE && !act_template_i[pmw_pkg::CPU_BIT]) begin
                    s_d.cpu_off = 1'b1;
                end
            end
            pmw_pkg::PMW_LOWPWR: begin
                if (s_q.mode == pmw_pkg::PMW_HIBERNATE && s_q.low_s2) begin
                    s_d.hibernate_low_voltage_reset = 1'b1; // [R13]
                end
                if (wake_ev) begin
                    // count already allows for the sync stages ahead of this point
                    s_d.state      = pmw_pkg::PMW_RESUME;
                    s_d.resume_cnt = (s_q.mode == pmw_pkg::PMW_HIBERNATE)
                                   ? pmw_pkg::RESUME_W'(pmw_pkg::HIB_RESUME_CYC)  // [R11]
                                   : pmw_pkg::RESUME_W'(pmw_pkg::SLEEP_RESUME_CYC); // [R9]
                end
            end
            pmw_pkg::PMW_RESUME: begin
                if (s_q.resume_cnt == '0) begin
                    s_d.state   = pmw_pkg::PMW_RUN;
                    s_d.mode    = pmw_pkg::PMW_ACTIVE; // [R5]
                    s_d.cpu_off = 1'b0;
                    s_d.wake    = 1'b1;
                end else begin
                    s_d.resume_cnt = s_q.resume_cnt - 1'b1;
                end
            end
            default: begin
                s_d.state = pmw_pkg::PMW_RUN;
            end
        endcase

        // subsystem enables from the template of the mode now in force
        case (s_d.mode)
            pmw_pkg::PMW_ACTIVE:     s_d.en = act_template_i; // [R2]
            pmw_pkg::PMW_ALT_ACTIVE: s_d.en = alt_template_i; // [R7]
            default:                 s_d.en = '0; // [R8] [R12]
        endcase
        if (s_d.state != pmw_pkg::PMW_RUN) begin
            s_d.en = '0;
        end else if (s_d.mode == pmw_pkg::PMW_ACTIVE) begin
            s_d.en[pmw_pkg::CPU_BIT] = ~s_d.cpu_off;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s_q            <= '0;
            s_q.rst_s1     <= 3'h0;
            s_q.mode       <= pmw_pkg::PMW_ACTIVE; // [R6]
            s_q.state      <= pmw_pkg::PMW_RUN;
            s_q.tw         <= pmw_pkg::TW_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mode_o                        = s_q.mode;
    assign subsys_en_o                   = s_q.en;
    assign clk_gate_en_o                 = s_q.en; // [R3]
    // hibernate stops all clocks while retention stays on [R12]
    assign clocks_run_o                  = !(s_q.mode == pmw_pkg::PMW_HIBERNATE && s_q.state != pmw_pkg::PMW_RUN);
    assign retain_o                      = (s_q.mode == pmw_pkg::PMW_HIBERNATE);
    assign wake_pulse_o                  = s_q.wake;
    assign hibernate_low_voltage_reset_o = s_q.hibernate_low_voltage_reset;
    assign central_timewheel_o           = s_q.tw;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    // ------------------------------------------------------------
    // checks: mode requests, templates and the cpu bit
    // ------------------------------------------------------------
    boot_active_a: assert property ( // [R6]
        $fell(reset_i) |-> (mode_o == pmw_pkg::PMW_ACTIVE && subsys_en_o == '0))
        else $error("mode not active after reset");
    req_taken_a: assert property ( // [R1]
        (s_q.state == pmw_pkg::PMW_RUN && mode_req_i && !wake_ev) |=> mode_o == $past(mode_sel_i))
        else $error("mode request not taken");
    active_template_a: assert property ( // [R2]
        (s_q.state == pmw_pkg::PMW_RUN && mode_o == pmw_pkg::PMW_ACTIVE && $stable(act_template_i)
         && !mode_req_i && !wake_ev)
        |=> subsys_en_o[pmw_pkg::NUM_SUBSYS-1:1] == $past(act_template_i[pmw_pkg::NUM_SUBSYS-1:1]))
        else $error("active template not applied");
    gate_tracks_template_a: assert property ( // [R3]
        (s_q.state == pmw_pkg::PMW_RUN && mode_o == pmw_pkg::PMW_ACTIVE && !mode_req_i && !wake_ev)
        |=> clk_gate_en_o[pmw_pkg::NUM_SUBSYS-1:1] == $past(act_template_i[pmw_pkg::NUM_SUBSYS-1:1]))
        else $error("clock gate does not follow template");
    cpu_self_off_a: assert property ( // [R4]
        (s_q.state == pmw_pkg::PMW_RUN && mode_o == pmw_pkg::PMW_ACTIVE && !mode_req_i && !wake_ev
         && !act_template_i[pmw_pkg::CPU_BIT])
        |=> !subsys_en_o[pmw_pkg::CPU_BIT])
        else $error("cpu stayed on after clearing its bit");
    wake_cpu_on_a: assert property ( // [R4] [R5]
        wake_pulse_o |-> (mode_o == pmw_pkg::PMW_ACTIVE && subsys_en_o[pmw_pkg::CPU_BIT]))
        else $error("wakeup without cpu enable");
    alt_template_a: assert property ( // [R7]
        (s_q.state == pmw_pkg::PMW_RUN && mode_o == pmw_pkg::PMW_ALT_ACTIVE && !mode_req_i && !wake_ev)
        |=> subsys_en_o == $past(alt_template_i))
        else $error("alternate template not applied");

    // ------------------------------------------------------------
    // checks: low-power entry, stay and exit, and wake synchronisation
    // ------------------------------------------------------------
    // resume bounds count from the first synchronised wake sample
    lowpwr_entry_a: assert property ( // [R8]
        (s_q.state == pmw_pkg::PMW_RUN && mode_req_i && !wake_ev
         && (mode_sel_i == pmw_pkg::PMW_SLEEP || mode_sel_i == pmw_pkg::PMW_HIBERNATE))
        |=> (s_q.state == pmw_pkg::PMW_LOWPWR && subsys_en_o == '0))
        else $error("low-power entry left subsystems on");
    sleep_gates_all_a: assert property ( // [R8]
        (s_q.mode == pmw_pkg::PMW_SLEEP && s_q.state == pmw_pkg::PMW_LOWPWR) |-> subsys_en_o == '0)
        else $error("subsystem enabled in sleep");
    sleep_resume_time_a: assert property ( // [R9]
        (s_q.state == pmw_pkg::PMW_LOWPWR && s_q.mode == pmw_pkg::PMW_SLEEP && wake_ev)
        |-> ##[1:120] (mode_o == pmw_pkg::PMW_ACTIVE && s_q.state == pmw_pkg::PMW_RUN))
        else $error("sleep resume too slow");
    disabled_src_a: assert property ( // [R14]
        (s_q.state == pmw_pkg::PMW_LOWPWR && s_q.mode == pmw_pkg::PMW_SLEEP && irq_q == '0 && rst_q == '0)
        |=> s_q.state == pmw_pkg::PMW_LOWPWR)
        else $error("sleep left without an enabled source");
    hib_resume_time_a: assert property ( // [R11]
        (s_q.state == pmw_pkg::PMW_LOWPWR && s_q.mode == pmw_pkg::PMW_HIBERNATE && wake_ev)
        |-> ##[1:1000] (mode_o == pmw_pkg::PMW_ACTIVE && s_q.state == pmw_pkg::PMW_RUN))
        else $error("hibernate resume too slow");
    hib_pin_only_a: assert property ( // [R10]
        (s_q.state == pmw_pkg::PMW_LOWPWR && s_q.mode == pmw_pkg::PMW_HIBERNATE && !irq_q[pmw_pkg::SRC_PIN])
        |=> s_q.state == pmw_pkg::PMW_LOWPWR)
        else $error("hibernate left without pin interrupt");
    hib_clocks_stop_a: assert property ( // [R12]
        (s_q.state != pmw_pkg::PMW_RUN && s_q.mode == pmw_pkg::PMW_HIBERNATE)
        |-> (!clocks_run_o && retain_o && subsys_en_o == '0))
        else $error("clocks or subsystems running in hibernate");
    hibernate_low_voltage_reset_cause_a: assert property ( // [R13]
        hibernate_low_voltage_reset_o |-> $past(s_q.low_s2) && $past(s_q.mode) == pmw_pkg::PMW_HIBERNATE)
        else $error("low voltage reset without cause");
    sync_wake_a: assert property ( // [R19]
        (wake_pulse_o && $past(s_q.state) == pmw_pkg::PMW_RUN)
        |-> ($past(|irq_i, 3) || $past(|rst_raw, 3)))
        else $error("wake taken without a synchronised source");

    // ------------------------------------------------------------
    // checks: timewheel
    // ------------------------------------------------------------
    tw_frozen_a: assert property ( // [R18]
        (retain_o && !tw_clear_i) |=> central_timewheel_o == $past(central_timewheel_o))
        else $error("timewheel ran in hibernate");
    tw_counts_a: assert property ( // [R18]
        (!retain_o && !tw_clear_i && s_q.tick_s2 && !s_q.tick_s3)
        |=> central_timewheel_o == pmw_pkg::TW_WIDTH'($past(central_timewheel_o) + 1'b1))
        else $error("timewheel missed a tick");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    sleep_wake_c: cover property (s_q.mode == pmw_pkg::PMW_SLEEP ##[1:200] wake_pulse_o);
    hib_wake_c:   cover property (s_q.mode == pmw_pkg::PMW_HIBERNATE ##[1:1000] wake_pulse_o);
    alt_mode_c:   cover property (mode_o == pmw_pkg::PMW_ALT_ACTIVE);
    hibernate_low_voltage_reset_c:       cover property (hibernate_low_voltage_reset_o);
    cpu_back_c:   cover property (s_q.cpu_off ##1 !s_q.cpu_off);

endmodule

// ---- pmw_pkg.sv ----
// pmw_pkg: constants and types shared by the power mode / wakeup controller.
// assumes a 10 MHz system clock; no register bus, all controls are ports.
package pmw_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_SUBSYS = 8;
    localparam int CPU_BIT    = 0;
    localparam int NUM_IRQ    = 4;
    localparam int TW_WIDTH   = 13;

    // wake interrupt source positions
    localparam int SRC_PERIPH = 0;
    localparam int SRC_SUPERV = 1;
    localparam int SRC_TWHEEL = 2;
    localparam int SRC_PIN    = 3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 100;
    localparam int SLEEP_RESUME_NS = 12000;
    localparam int HIB_RESUME_NS   = 100000;
    // cycles outside the countdown: two sync stages, entry to resume, exit to
    // active, and one cycle of margin, so pin-to-active stays under the bound
    localparam int RESUME_OVH_CYC   = 5;
    localparam int SLEEP_RESUME_CYC = SLEEP_RESUME_NS / CLK_PERIOD_NS - RESUME_OVH_CYC;
    localparam int HIB_RESUME_CYC   = HIB_RESUME_NS / CLK_PERIOD_NS - RESUME_OVH_CYC;
    localparam int RESUME_W         = 11;

    localparam logic [TW_WIDTH-1:0] TW_RESET = 13'h0000;

    // global modes, ordered from highest to lowest consumption
    typedef enum logic [1:0] {
        PMW_ACTIVE,
        PMW_ALT_ACTIVE,
        PMW_SLEEP,
        PMW_HIBERNATE
    } pmw_mode_t;

    typedef enum logic [1:0] {
        PMW_RUN,
        PMW_LOWPWR,
        PMW_RESUME
    } pmw_state_t;

endpackage

// ---- pmw_ctrl_tb_top.sv ----
// pmw_ctrl_tb_top: self-checking bench for the power mode / wakeup controller.
// assumes pmw_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/100ps
module pmw_ctrl_tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                               clock_i;
    logic                               reset_i;
    logic                               mode_req_i;
    pmw_pkg::pmw_mode_t                 mode_sel_i;
    logic [7:0]                         act_template_i;
    logic [7:0]                         alt_template_i;
    logic [3:0]                         irq_i;
    logic [3:0]                         irq_wake_en_i;
    logic                               external_reset_pin_n_i;
    logic                               watchdog_reset_i;
    logic                               precise_low_voltage_reset_i;
    logic [2:0]                         rst_wake_en_i;
    logic                               supply_low_i;
    logic                               tick_1khz_i;
    logic                               tw_clear_i;
    pmw_pkg::pmw_mode_t                 mode_o;
    logic [7:0]                         subsys_en_o;
    logic [7:0]                         clk_gate_en_o;
    logic                               clocks_run_o;
    logic                               retain_o;
    logic                               wake_pulse_o;
    logic                               hibernate_low_voltage_reset_o;
    logic [12:0]                        central_timewheel_o;
    int                                 fails;
    int                                 checks;
    int                                 cycles;
    logic [12:0]                        tw_held;

    pmw_ctrl u_pmw_ctrl (
        .clock_i(clock_i), .reset_i(reset_i), .mode_req_i(mode_req_i), .mode_sel_i(mode_sel_i),
        .act_template_i(act_template_i), .alt_template_i(alt_template_i), .irq_i(irq_i),
        .irq_wake_en_i(irq_wake_en_i), .external_reset_pin_n_i(external_reset_pin_n_i),
        .watchdog_reset_i(watchdog_reset_i), .precise_low_voltage_reset_i(precise_low_voltage_reset_i),
        .rst_wake_en_i(rst_wake_en_i), .supply_low_i(supply_low_i), .tick_1khz_i(tick_1khz_i),
        .tw_clear_i(tw_clear_i), .mode_o(mode_o), .subsys_en_o(subsys_en_o), .clk_gate_en_o(clk_gate_en_o),
        .clocks_run_o(clocks_run_o), .retain_o(retain_o), .wake_pulse_o(wake_pulse_o),
        .hibernate_low_voltage_reset_o(hibernate_low_voltage_reset_o),
        .central_timewheel_o(central_timewheel_o));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    // the whole run needs about 2300 cycles; the ceiling leaves ample slack
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 10000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // inputs always change 10 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #10;
    endtask

    // no pll here: the bench stands for firmware that has already stopped it
    task automatic req(input pmw_pkg::pmw_mode_t m);
        mode_sel_i = m;
        mode_req_i = 1'b1;
        step(1);
        mode_req_i = 1'b0;
        step(1);
    endtask

    task automatic tick(input int k);
        repeat (k) begin
            tick_1khz_i = 1'b1;
            step(4);
            tick_1khz_i = 1'b0;
            step(4);
        end
    endtask

    // waits for the return to active; the pulse must stand in that same cycle
    task automatic wait_act(input int limit);
        int n;
        n = 0;
        while (mode_o !== pmw_pkg::PMW_ACTIVE && n < limit) begin
            step(1);
            n++;
        end
        chk(16'(mode_o), 16'(pmw_pkg::PMW_ACTIVE));
        chk(16'(wake_pulse_o), 16'h0001);
        chk(16'(subsys_en_o[0]), 16'h0001);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_templates();
        chk(16'(mode_o), 16'(pmw_pkg::PMW_ACTIVE));
        act_template_i = 8'ha5;
        step(2);
        chk(16'(subsys_en_o), 16'h00a5);
        chk(16'(clk_gate_en_o), 16'h00a5);
        act_template_i = 8'h5b;
        step(2);
        chk(16'(subsys_en_o), 16'h005b);
        alt_template_i = 8'h3c;
        req(pmw_pkg::PMW_ALT_ACTIVE);
        chk(16'(mode_o), 16'(pmw_pkg::PMW_ALT_ACTIVE));
        chk(16'(subsys_en_o), 16'h003c);
        req(pmw_pkg::PMW_ACTIVE);
        chk(16'(subsys_en_o), 16'h005b);
    endtask

    task automatic t_sleep_wakes();
        irq_wake_en_i = 4'hd;
        req(pmw_pkg::PMW_SLEEP);
        chk(16'(subsys_en_o), 16'h0000);
        irq_i = 4'h2;
        step(150);
        chk(16'(mode_o), 16'(pmw_pkg::PMW_SLEEP));
        irq_i = 4'h0;
        irq_wake_en_i = 4'hf;
        step(4);
        for (int s = 0; s < 4; s++) begin
            req(pmw_pkg::PMW_SLEEP);
            irq_i[s] = 1'b1;
            wait_act(124);
            irq_i = 4'h0;
            step(4);
        end
        for (int r = 0; r < 3; r++) begin
            req(pmw_pkg::PMW_SLEEP);
            external_reset_pin_n_i = (r != 0);
            watchdog_reset_i = (r == 1);
            precise_low_voltage_reset_i = (r == 2);
            wait_act(124);
            external_reset_pin_n_i = 1'b1;
            watchdog_reset_i = 1'b0;
            precise_low_voltage_reset_i = 1'b0;
            step(4);
        end
    endtask

    task automatic t_cpu_self_off();
        act_template_i = 8'hfe;
        step(2);
        chk(16'(subsys_en_o), 16'h00fe);
        act_template_i = 8'hff;
        step(2);
        chk(16'(subsys_en_o[0]), 16'h0000);
        irq_i = 4'h1;
        step(6);
        chk(16'(subsys_en_o[0]), 16'h0001);
        irq_i = 4'h0;
        step(4);
    endtask

    task automatic t_timewheel();
        tw_clear_i = 1'b1;
        step(1);
        tw_clear_i = 1'b0;
        step(1);
        chk(16'(central_timewheel_o), 16'h0000);
        tick(3);
        chk(16'(central_timewheel_o), 16'h0003);
    endtask

    task automatic t_hibernate();
        tw_held = central_timewheel_o;
        req(pmw_pkg::PMW_HIBERNATE);
        chk(16'(retain_o), 16'h0001);
        chk(16'(clocks_run_o), 16'h0000);
        irq_i = 4'h7;
        watchdog_reset_i = 1'b1;
        tick(3);
        step(150);
        chk(16'(mode_o), 16'(pmw_pkg::PMW_HIBERNATE));
        chk(16'(central_timewheel_o), 16'(tw_held));
        chk(16'(hibernate_low_voltage_reset_o), 16'h0000);
        supply_low_i = 1'b1;
        step(4);
        chk(16'(hibernate_low_voltage_reset_o), 16'h0001);
        supply_low_i = 1'b0;
        irq_i = 4'h0;
        watchdog_reset_i = 1'b0;
        step(4);
        irq_i[3] = 1'b1;
        wait_act(1004);
        chk(16'(retain_o), 16'h0000);
        chk(16'(clocks_run_o), 16'h0001);
        irq_i = 4'h0;
        step(4);
    endtask

    initial begin
        {mode_req_i, tw_clear_i, supply_low_i, tick_1khz_i, watchdog_reset_i} = 5'h00;
        precise_low_voltage_reset_i = 1'b0;
        external_reset_pin_n_i = 1'b1;
        mode_sel_i = pmw_pkg::PMW_ACTIVE;
        {act_template_i, alt_template_i} = 16'hffff;
        {irq_i, irq_wake_en_i} = 8'h0f;
        rst_wake_en_i = 3'h7;
        {fails, checks, cycles} = {32'd0, 32'd0, 32'd0};
        reset_i = 1'b1;
        step(20);
        reset_i = 1'b0;
        step(1);
        t_templates();
        t_sleep_wakes();
        t_cpu_self_off();
        t_timewheel();
        t_hibernate();
        wrap_up();
    end
endmodule
